// ---- inc/ccr_pkg.sv ----
`default_nettype none
package ccr_pkg;
    localparam int CCR_NREG = 14;
    localparam int CCR_NCH = 4;
    localparam int CCR_W = 24;
    // Register slots, in address order
    localparam int SLOT_CURRENT1_GAIN = 0;
    localparam int SLOT_VOLTAGE1_DC_OFFSET = 1;
    localparam int SLOT_VOLTAGE1_GAIN = 2;
    localparam int SLOT_ACTIVE_POWER1_OFFSET = 3;
    localparam int SLOT_CURRENT1_AC_OFFSET = 4;
    localparam int SLOT_REACTIVE_POWER1_OFFSET = 5;
    localparam int SLOT_CURRENT2_GAIN = 6;
    localparam int SLOT_VOLTAGE2_DC_OFFSET = 7;
    localparam int SLOT_VOLTAGE2_GAIN = 8;
    localparam int SLOT_ACTIVE_POWER2_OFFSET = 9;
    localparam int SLOT_CURRENT2_AC_OFFSET = 10;
    localparam int SLOT_REACTIVE_POWER2_OFFSET = 11;
    localparam int SLOT_TEMPERATURE_SCALE = 12;
    localparam int SLOT_TEMPERATURE_SHIFT = 13;
    localparam logic [0:13][5:0] CCR_ADDR = '{
        6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28,
        6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h36, 6'h37};
    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam logic [23:0] ZERO24 = 24'h000000;
    localparam logic [23:0] TSCALE_RST = 24'h06B716;
    localparam logic [23:0] TSHIFT_RST = 24'hD53998;
    localparam logic [23:0] POS_MAX = 24'h7FFFFF;
    localparam logic [23:0] NEG_MAX = 24'h800000;
    localparam logic [23:0] ALL_ONES = 24'hFFFFFF;
    localparam logic [0:13][23:0] CCR_RST = '{
        GAIN_UNITY, ZERO24, GAIN_UNITY, ZERO24, ZERO24, ZERO24, GAIN_UNITY,
        ZERO24, GAIN_UNITY, ZERO24, ZERO24, ZERO24, TSCALE_RST, TSHIFT_RST};
    // Channel order: 0 voltage1, 1 current1, 2 voltage2, 3 current2
    localparam logic [0:3][3:0] GAIN_SLOT = '{4'd2, 4'd0, 4'd8, 4'd6};
    localparam logic [0:3][3:0] DC_SLOT = '{4'd1, 4'd0, 4'd7, 4'd0};
    localparam logic [0:3] CH_IS_VOLT = 4'b1010;
    // Reciprocal: 2^44 / gain, one dividend bit per cycle
    localparam logic [5:0] DIV_LAST_BIT = 6'd44;
    localparam int TEMP_FRAC = 16;

    typedef enum logic [1:0] {
        CCR_IDLE = 2'b00,
        CCR_DIV = 2'b01,
        CCR_FIN = 2'b10
    } ccr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [23:0] wdata;
    } ccr_reg_req_t;

    typedef struct packed {
        logic start;
        logic gain_kind;
        logic [3:0] sel;
        logic [3:0][23:0] meas;
    } ccr_cal_req_t;

    typedef struct packed {
        logic [23:0] p1;
        logic [23:0] q1;
        logic [23:0] p2;
        logic [23:0] q2;
        logic [23:0] irms1;
        logic [23:0] irms2;
        logic [23:0] temp;
    } ccr_meas_t;
endpackage
`default_nettype wire

// ---- rtl/ccr_bank.sv ----
// Contract
// - Reset clears both voltage DC offsets
// - DC calibration stores negated measured offset
// - Host may write DC offsets directly
// - DC offsets are signed one-dot-23 fractions
// - Reset loads all gains with unity
// - Gain calibration stores reciprocal of gain
// - Gains are unsigned two-dot-22 values
// - Active offset added to averaged active power
// - Reactive offset added to averaged reactive power
// - AC offsets reset zero, act on RMS
// - AC offsets are unsigned pure fractions
// - Raw temperature multiplied by temperature scale
// - Temperature scale is unsigned eight-dot-16
// - Signed temperature shift added after scaling
// - Data ready raised when calibration completes
`timescale 1ns/1ps
`default_nettype none
module ccr_bank (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire ccr_pkg::ccr_reg_req_t reg_req_i,
    output var logic [23:0] reg_rdata_o,
    input wire ccr_pkg::ccr_cal_req_t cal_req_i,
    output var logic cal_busy_o,
    output var logic cal_done_o,
    input wire logic data_ready_flag_clear_i,
    output var logic data_ready_flag_o,
    input wire logic meas_valid_i,
    input wire ccr_pkg::ccr_meas_t meas_i,
    output var ccr_pkg::ccr_meas_t result_o
);
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ccr_pkg::ccr_state_t state;
    ccr_pkg::ccr_state_t next_state;
    logic [5:0] bit_cnt;
    logic [3:0] sel_q;
    logic [23:0] coef [ccr_pkg::CCR_NREG];
    logic [ccr_pkg::CCR_NREG-1:0] host_hit;
    logic [ccr_pkg::CCR_NREG-1:0] cal_wr;
    logic [23:0] cal_val [ccr_pkg::CCR_NREG];
    logic [3:0] gain_wr;
    logic [3:0] dc_wr;
    logic [23:0] gain_res [ccr_pkg::CCR_NCH];
    logic [23:0] dc_res [ccr_pkg::CCR_NCH];
    logic [23:0] next_rdata;

    wire idle = (state == ccr_pkg::CCR_IDLE);
    wire start_ok = idle && cal_req_i.start;
    wire start_gain = start_ok && cal_req_i.gain_kind;
    wire start_dc = start_ok && !cal_req_i.gain_kind;
    wire div_end = (state == ccr_pkg::CCR_DIV) && (bit_cnt == 6'd0);
    wire fin = (state == ccr_pkg::CCR_FIN);

    always_comb begin
        next_state = state;
        unique case (state)
            ccr_pkg::CCR_IDLE: begin
                if (start_gain) begin
                    next_state = ccr_pkg::CCR_DIV;
                end
            end
            ccr_pkg::CCR_DIV: begin
                if (div_end) begin
                    next_state = ccr_pkg::CCR_FIN;
                end
            end
            ccr_pkg::CCR_FIN: next_state = ccr_pkg::CCR_IDLE;
            default: next_state = ccr_pkg::CCR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ccr_pkg::CCR_IDLE;
            bit_cnt <= 6'd0;
            sel_q <= 4'h0;
        end else begin
            state <= next_state;
            if (start_gain) begin
                bit_cnt <= ccr_pkg::DIV_LAST_BIT;
                sel_q <= cal_req_i.sel;
            end else if (state == ccr_pkg::CCR_DIV && bit_cnt != 6'd0) begin
                bit_cnt <= bit_cnt - 6'd1;
            end
        end
    end

    // Per-channel calibration math
    genvar c;
    generate
        for (c = 0; c < ccr_pkg::CCR_NCH; c++) begin : g_ch
            logic [24:0] rem;
            logic [23:0] quo;
            logic [23:0] den;
            logic ovf;
            wire dbit = (bit_cnt == ccr_pkg::DIV_LAST_BIT);
            wire [24:0] trial = {rem[23:0], dbit};
            wire take = (trial >= {1'b0, den});
            wire [24:0] next_rem = take ? (trial - {1'b0, den}) : trial;
            wire [23:0] m = cal_req_i.meas[c];
            wire [23:0] neg = 24'(~m + 24'h000001);
            always_ff @(posedge clk_sys_i or negedge rst_n) begin
                if (!rst_n) begin
                    rem <= 25'h0000000;
                    quo <= 24'h000000;
                    den <= 24'h000000;
                    ovf <= 1'b0;
                end else if (start_gain) begin
                    rem <= 25'h0000000;
                    quo <= 24'h000000;
                    den <= m;
                    ovf <= 1'b0;
                end else if (state == ccr_pkg::CCR_DIV) begin
                    rem <= next_rem;
                    quo <= {quo[22:0], take};
                    ovf <= ovf | quo[23];
                end
            end
            // Quotient above 4.0 cannot be held, so it saturates
            assign gain_res[c] = ovf ? ccr_pkg::ALL_ONES : quo;
            // Minus one has no positive twin in this format
            assign dc_res[c] = (m == ccr_pkg::NEG_MAX) ? ccr_pkg::POS_MAX : neg;
            assign gain_wr[c] = fin && sel_q[c];
            assign dc_wr[c] = start_dc && cal_req_i.sel[c] && ccr_pkg::CH_IS_VOLT[c];
        end
    endgenerate

    always_comb begin
        for (int k = 0; k < ccr_pkg::CCR_NREG; k++) begin
            cal_wr[k] = 1'b0;
            cal_val[k] = ccr_pkg::ZERO24;
            for (int j = 0; j < ccr_pkg::CCR_NCH; j++) begin
                if (gain_wr[j] && ccr_pkg::GAIN_SLOT[j] == 4'(k)) begin
                    cal_wr[k] = 1'b1;
                    cal_val[k] = gain_res[j];
                end
                if (dc_wr[j] && ccr_pkg::DC_SLOT[j] == 4'(k)) begin
                    cal_wr[k] = 1'b1;
                    cal_val[k] = dc_res[j];
                end
            end
        end
    end

    // Coefficient store; calibration beats a host write in the same cycle
    genvar k;
    generate
        for (k = 0; k < ccr_pkg::CCR_NREG; k++) begin : g_reg
            assign host_hit[k] = reg_req_i.wr && (reg_req_i.addr == ccr_pkg::CCR_ADDR[k]);
            always_ff @(posedge clk_sys_i or negedge rst_n) begin
                if (!rst_n) begin
                    coef[k] <= ccr_pkg::CCR_RST[k];
                end else if (cal_wr[k]) begin
                    coef[k] <= cal_val[k];
                end else if (host_hit[k]) begin
                    coef[k] <= reg_req_i.wdata;
                end
            end
        end
    endgenerate

    always_comb begin
        next_rdata = ccr_pkg::ZERO24;
        for (int r = 0; r < ccr_pkg::CCR_NREG; r++) begin
            if (reg_req_i.addr == ccr_pkg::CCR_ADDR[r]) begin
                next_rdata = coef[r];
            end
        end
    end

    // Result datapath
    function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
        logic [24:0] s;
        s = {a[23], a} + {b[23], b};
        if (s[24] != s[23]) begin
            sat_add = s[24] ? ccr_pkg::NEG_MAX : ccr_pkg::POS_MAX;
        end else begin
            sat_add = s[23:0];
        end
    endfunction

    function automatic logic [23:0] rms_trim(input logic [23:0] raw, input logic [23:0] off);
        logic [24:0] d;
        d = {1'b0, raw} - {1'b0, off};
        rms_trim = d[24] ? ccr_pkg::ZERO24 : d[23:0];
    endfunction

    wire signed [48:0] t_prod = $signed(meas_i.temp) *
        $signed({1'b0, coef[ccr_pkg::SLOT_TEMPERATURE_SCALE]});
    wire [23:0] t_shift = coef[ccr_pkg::SLOT_TEMPERATURE_SHIFT];
    wire signed [48:0] t_sum = t_prod +
        $signed({{9{t_shift[23]}}, t_shift, 16'h0000});
    // Keep 8.16 out of a 16.32 sum, clamping what does not fit
    wire t_fits = (t_sum[48:39] == {10{t_sum[39]}});
    wire [23:0] t_res = t_fits ? t_sum[39:16] :
        (t_sum[48] ? ccr_pkg::NEG_MAX : ccr_pkg::POS_MAX);

    ccr_pkg::ccr_meas_t next_result;
    always_comb begin
        next_result.p1 = sat_add(meas_i.p1, coef[ccr_pkg::SLOT_ACTIVE_POWER1_OFFSET]);
        next_result.p2 = sat_add(meas_i.p2, coef[ccr_pkg::SLOT_ACTIVE_POWER2_OFFSET]);
        next_result.q1 = sat_add(meas_i.q1, coef[ccr_pkg::SLOT_REACTIVE_POWER1_OFFSET]);
        next_result.q2 = sat_add(meas_i.q2, coef[ccr_pkg::SLOT_REACTIVE_POWER2_OFFSET]);
        next_result.irms1 = rms_trim(meas_i.irms1, coef[ccr_pkg::SLOT_CURRENT1_AC_OFFSET]);
        next_result.irms2 = rms_trim(meas_i.irms2, coef[ccr_pkg::SLOT_CURRENT2_AC_OFFSET]);
        next_result.temp = t_res;
    end

    wire cal_finish = fin || start_dc;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 24'h000000;
            cal_busy_o <= 1'b0;
            cal_done_o <= 1'b0;
            data_ready_flag_o <= 1'b0;
            result_o <= '0;
        end else begin
            if (reg_req_i.rd) begin
                reg_rdata_o <= next_rdata;
            end
            cal_busy_o <= (next_state != ccr_pkg::CCR_IDLE);
            cal_done_o <= cal_finish;
            // Set wins so a completion is never lost to a clear
            if (cal_finish) begin
                data_ready_flag_o <= 1'b1;
            end else if (data_ready_flag_clear_i) begin
                data_ready_flag_o <= 1'b0;
            end
            if (meas_valid_i) begin
                result_o <= next_result;
            end
        end
    end

    // Checks
    dc_cal_neg_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (start_dc && cal_req_i.sel[0] && cal_req_i.meas[0] != ccr_pkg::NEG_MAX)
        |=> coef[ccr_pkg::SLOT_VOLTAGE1_DC_OFFSET] == 24'(-$past(cal_req_i.meas[0])))
        else $error("voltage1 offset not negated measurement");

    host_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (host_hit[ccr_pkg::SLOT_VOLTAGE2_DC_OFFSET] && !cal_wr[ccr_pkg::SLOT_VOLTAGE2_DC_OFFSET])
        |=> coef[ccr_pkg::SLOT_VOLTAGE2_DC_OFFSET] == $past(reg_req_i.wdata))
        else $error("host write to voltage2 offset lost");

    gain_unity_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (start_gain && cal_req_i.sel[1] && cal_req_i.meas[1] == ccr_pkg::GAIN_UNITY)
        |=> cal_busy_o [*8] ##[38:40] (cal_done_o
        && coef[ccr_pkg::SLOT_CURRENT1_GAIN] == ccr_pkg::GAIN_UNITY))
        else $error("unity gain calibration result or timing wrong");

    unselected_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (fin && !sel_q[2] && !host_hit[ccr_pkg::SLOT_VOLTAGE2_GAIN])
        |=> $stable(coef[ccr_pkg::SLOT_VOLTAGE2_GAIN]))
        else $error("unselected gain changed by calibration");

    active_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (meas_valid_i && meas_i.p1 == 24'h000000)
        |=> result_o.p1 == $past(coef[ccr_pkg::SLOT_ACTIVE_POWER1_OFFSET]))
        else $error("active power offset not applied");

    reactive_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (meas_valid_i && coef[ccr_pkg::SLOT_REACTIVE_POWER2_OFFSET] == 24'h000000)
        |=> result_o.q2 == $past(meas_i.q2))
        else $error("zero reactive offset altered result");

    rms_floor_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (meas_valid_i && meas_i.irms1 < coef[ccr_pkg::SLOT_CURRENT1_AC_OFFSET])
        |=> result_o.irms1 == 24'h000000)
        else $error("rms below ac offset not floored");

    temp_unity_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (meas_valid_i && coef[ccr_pkg::SLOT_TEMPERATURE_SCALE] == 24'h010000
        && coef[ccr_pkg::SLOT_TEMPERATURE_SHIFT] == 24'h000000)
        |=> result_o.temp == $past(meas_i.temp))
        else $error("unity temperature scale changed result");

    data_ready_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        cal_finish |=> (cal_done_o && data_ready_flag_o))
        else $error("data ready not raised on completion");

    cov_dc_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n) start_dc);
    cov_gain_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        fin ##1 cal_done_o);
    cov_write_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n) |host_hit);
    cov_clear_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        data_ready_flag_o ##1 !data_ready_flag_o);
endmodule // ccr_bank
`default_nettype wire

// ---- verif/ccr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
    input wire logic clk_sys_i,
    input wire logic [23:0] reg_rdata_i,
    output var ccr_pkg::ccr_reg_req_t reg_req_o
);
    initial begin
        reg_req_o = '0;
    end
    // Released port carries scrambled fields so stale values never match
    task automatic idle();
        reg_req_o.wr = 1'b0;
        reg_req_o.rd = 1'b0;
        reg_req_o.addr = ~reg_req_o.addr;
        reg_req_o.wdata = ~reg_req_o.wdata;
    endtask
    task automatic write(input logic [5:0] a, input logic [23:0] d);
        @(negedge clk_sys_i);
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys_i);
        idle();
    endtask
    task automatic read(input logic [5:0] a, output logic [23:0] d);
        @(negedge clk_sys_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req_o.wdata};
        @(negedge clk_sys_i);
        d = reg_rdata_i;
        idle();
    endtask
endmodule // ccr_host
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    ccr_pkg::ccr_reg_req_t reg_req;
    ccr_pkg::ccr_cal_req_t cal_req = '0;
    ccr_pkg::ccr_meas_t meas = '0;
    ccr_pkg::ccr_meas_t result;
    logic [23:0] reg_rdata;
    logic [23:0] rdata;
    logic [23:0] shadow [0:13];
    logic [3:0][23:0] m;
    logic cal_busy, cal_done, data_ready_flag;
    logic data_ready_flag_clear = 1'b0;
    logic meas_valid = 1'b0;
    int errors = 0;
    int compares = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    ccr_bank u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req),
        .reg_rdata_o(reg_rdata), .cal_req_i(cal_req), .cal_busy_o(cal_busy),
        .cal_done_o(cal_done), .data_ready_flag_clear_i(data_ready_flag_clear), .data_ready_flag_o(data_ready_flag),
        .meas_valid_i(meas_valid), .meas_i(meas), .result_o(result));
    ccr_host u_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_req_o(reg_req));

    task automatic wrap_up();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic longint sx(input logic [23:0] v);
        return longint'($signed(v));
    endfunction
    function automatic logic [23:0] sat(input longint v);
        if (v > 64'sh7FFFFF) return 24'h7FFFFF;
        if (v < -64'sh800000) return 24'h800000;
        return v[23:0];
    endfunction
    function automatic logic [23:0] recip(input logic [23:0] g);
        longint q;
        if (g == 24'h000000) return 24'hFFFFFF;
        q = 64'h100000000000 / g;
        return (q > 64'hFFFFFF) ? 24'hFFFFFF : q[23:0];
    endfunction
    task automatic check_bank();
        for (int i = 0; i < ccr_pkg::CCR_NREG; i++) begin
            u_host.read(ccr_pkg::CCR_ADDR[i], rdata);
            cmp(rdata, shadow[i]);
        end
    endtask
    task automatic calibrate(input logic kind, input logic [3:0] sel, input logic [3:0][23:0] mv);
        int n;
        n = 0;
        @(negedge clk_sys_i);
        cal_req = '{start: 1'b1, gain_kind: kind, sel: sel, meas: mv};
        @(negedge clk_sys_i);
        cal_req.start = 1'b0;
        cal_req.meas = ~mv;
        if (kind) begin
            cmp_bit(cal_busy, 1'b1);
        end
        while (cal_done !== 1'b1) begin
            n++;
            if (n > 60) begin
                errors++;
                wrap_up();
            end
            @(negedge clk_sys_i);
        end
        cmp_bit(data_ready_flag, 1'b1);
    endtask
    task automatic load_reset();
        for (int i = 0; i < ccr_pkg::CCR_NREG; i++) begin
            shadow[i] = ccr_pkg::CCR_RST[i];
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h5683));
        load_reset();
        repeat (16) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        check_bank();
        u_host.read(6'h30, rdata);
        cmp(rdata, 24'h000000);
        for (int i = 0; i < ccr_pkg::CCR_NREG; i++) begin
            shadow[i] = 24'($urandom());
            u_host.write(ccr_pkg::CCR_ADDR[i], shadow[i]);
        end
        u_host.write(6'h3F, 24'hFFFFFF);
        check_bank();
        @(negedge clk_sys_i);
        data_ready_flag_clear = 1'b1;
        @(negedge clk_sys_i);
        data_ready_flag_clear = 1'b0;
        cmp_bit(data_ready_flag, 1'b0);
        // Most negative offset has no positive twin, so it must clip
        m = {24'($urandom()), 24'($urandom()), 24'($urandom()), 24'h800000};
        calibrate(1'b0, 4'b1111, m);
        shadow[1] = sat(-sx(m[0]));
        shadow[7] = sat(-sx(m[2]));
        check_bank();
        m = {24'h000000, 24'h100001 + 24'($urandom_range(0, 24'hEFFFFE)), 24'h200000,
            24'($urandom())};
        calibrate(1'b1, 4'b1110, m);
        shadow[0] = recip(m[1]);
        shadow[8] = recip(m[2]);
        shadow[6] = recip(m[3]);
        check_bank();
        // Unity gain on current1 alone; voltage2 gain must stay put
        m = {24'($urandom()), 24'($urandom()), 24'h400000, 24'($urandom())};
        calibrate(1'b1, 4'b0010, m);
        shadow[0] = recip(m[1]);
        check_bank();
        @(negedge clk_sys_i);
        cmp_bit(data_ready_flag, 1'b1);
        data_ready_flag_clear = 1'b1;
        @(negedge clk_sys_i);
        data_ready_flag_clear = 1'b0;
        cmp_bit(data_ready_flag, 1'b0);
        for (int t = 0; t < 24; t++) begin
            if (t % 8 == 0) begin
                shadow[12] = (t == 16) ? 24'h010000 : 24'($urandom_range(0, 3)) << 16;
                u_host.write(6'h36, shadow[12]);
                for (int i = 0; i < ccr_pkg::CCR_NREG; i++) begin
                    if (i inside {3, 4, 5, 9, 10, 11, 13}) begin
                        // Zero offsets once so the pass-through checks are reached
                        shadow[i] = (t == 16) ? 24'h000000 : 24'($urandom());
                        u_host.write(ccr_pkg::CCR_ADDR[i], shadow[i]);
                    end
                end
            end
            @(negedge clk_sys_i);
            meas = 168'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom(),
                $urandom()});
            if (t % 8 == 3) begin
                meas.p1 = 24'h000000;
            end
            meas_valid = 1'b1;
            @(negedge clk_sys_i);
            meas_valid = 1'b0;
            cmp(result.p1, sat(sx(meas.p1) + sx(shadow[3])));
            cmp(result.p2, sat(sx(meas.p2) + sx(shadow[9])));
            cmp(result.q1, sat(sx(meas.q1) + sx(shadow[5])));
            cmp(result.q2, sat(sx(meas.q2) + sx(shadow[11])));
            cmp(result.irms1, (meas.irms1 > shadow[4]) ? meas.irms1 - shadow[4] : 24'h0);
            cmp(result.irms2, (meas.irms2 > shadow[10]) ? meas.irms2 - shadow[10] : 24'h0);
            cmp(result.temp, sat(sx(meas.temp) * longint'(shadow[12] >> 16) + sx(shadow[13])));
        end
        arst_n_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        load_reset();
        cmp_bit(data_ready_flag, 1'b0);
        check_bank();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
